// ===== verilog/spm_pkg.sv
package spm_pkg;
  // control/status bit positions
  localparam int BIT_IE = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_RSV = 5;
  localparam int BIT_RRE = 4;
  localparam int BIT_LOCK = 3;
  localparam int BIT_PGW = 2;
  localparam int BIT_PGE = 1;
  localparam int BIT_EN = 0;
  localparam logic [7:0] CSR_RESET = 8'h00;
  // lower five bit commands
  localparam logic [4:0] CMD_RRE = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_PGW = 5'h05;
  localparam logic [4:0] CMD_PGE = 5'h03;
  localparam logic [4:0] CMD_FILL = 5'h01;
  // enable window in cycles
  localparam int WINDOW_CYC = 4;
  localparam int LPM_WINDOW_CYC = 3;
  // lock byte layout and erased value
  localparam int LB_BOOT_HI = 5;
  localparam int LB_BOOT_LO = 4;
  localparam int LB_APP_HI = 3;
  localparam int LB_APP_LO = 2;
  localparam int LB_MEM_HI = 1;
  localparam int LB_MEM_LO = 0;
  localparam logic [5:0] LOCK_ERASED = 6'h3f;
  // z pointer fields
  localparam int Z_PAGE_HI = 12;
  localparam int Z_PAGE_LO = 6;
  localparam int Z_WORD_HI = 5;
  localparam int Z_WORD_LO = 1;
  // first page of the no_read_while_write section
  localparam logic [6:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h60;
  // programming time in microseconds
  localparam int PROG_MIN_US = 3700;
  localparam int PROG_MAX_US = 4500;
  localparam int CLK_MHZ = 200;
  localparam int PROG_CYC = PROG_MIN_US * CLK_MHZ;
  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE, OP_LOCK} op_e;
endpackage

// ===== verilog/flash_req_if.sv
`timescale 1ns/1ps
interface flash_req_if;
  logic start;
  spm_pkg::op_e op;
  logic [6:0] page;
  logic [5:0] lock_data;
  logic busy;
  logic done;
  modport ctrl(output start, output op, output page, output lock_data,
               input busy, input done);
  modport timer(input start, input op, input page, input lock_data,
                output busy, output done);
endinterface

// ===== verilog/prog_timer.sv
`timescale 1ns/1ps
module prog_timer #(
  parameter int PROG_CYCLES = spm_pkg::PROG_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  flash_req_if.timer req
);
  logic [31:0] cnt_r;
  logic busy_r;
  logic done_r;
  wire cnt_last = (cnt_r == 32'h1);

  // ---------------------------------------------------------------
  // busy timer
  // ---------------------------------------------------------------
  // programming duration
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 32'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r && cnt_last;
      if (req.start && !busy_r) begin
        cnt_r <= 32'(PROG_CYCLES);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 32'h1;
        if (cnt_last) begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  assign req.busy = busy_r;
  assign req.done = done_r;
endmodule

// ===== verilog/page_buffer.sv
`timescale 1ns/1ps
module page_buffer #(
  parameter int WORDS = 32
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_wr,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic i_clear,
  output logic o_loading,
  output logic [15:0] o_word0
);
  logic [15:0] mem_r [WORDS];
  logic loading_r;

  // ---------------------------------------------------------------
  // storage, one flop set per word
  // ---------------------------------------------------------------
  for (genvar g = 0; g < WORDS; g++) begin : g_word
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        mem_r[g] <= 16'hffff;
      end else if (i_clear) begin
        mem_r[g] <= 16'hffff;
      end else if (i_wr && i_addr == 5'(g)) begin
        mem_r[g] <= i_data;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      loading_r <= 1'b0;
    end else if (i_clear) begin
      loading_r <= 1'b0;
    end else if (i_wr) begin
      loading_r <= 1'b1;
    end
  end

  assign o_loading = loading_r;
  assign o_word0 = mem_r[0];
endmodule

// ===== verilog/self_program_control_and_lock.sv
`timescale 1ns/1ps
// Behaviour
// - ready interrupt when enable bit and global flag set and enable clear
// - section_busy set on read_while_write erase or write, blocks its reads
// - section_busy cleared by read-enable action or by a buffer load
// - bit 5 reads zero, writes ignored
// - read-enable action needs finished programming; refused while busy
// - read-enable write during buffer load discards loaded data
// - lock-set action programs lock bits from R0, ignores and Z
// - lock_set clears on completion or four-cycle timeout
// - load within three cycles of lock_set returns lock or fuse byte
// - page_write writes buffer to page from upper Z bits
// - page_erase erases page from upper Z bits
// - page_write and page_erase clear on completion or timeout
// - core stalled during erase or write to no_read_while_write pages
// - plain enable: store places R1:R0 in buffer at Z word
// - enable bit opens four-cycle window; stays set while programming
// - only five lower-bit patterns act; others do nothing
// - six lock bits, 1 unprogrammed, restored only by chip erase or reset
// - store instruction allowed only when enable fuse is programmed
// - memory lock pair selects external programming protection
// - app lock pair blocks stores and boot-section loads of app
// - boot lock pair blocks stores and app-section loads; masks vectors
// - page number from Z bits 12 to 6
// - buffer word from Z bits 5 to 1, zero for page write
// - erase, write and lock set keep flash busy for programming time
module self_program_control_and_lock #(
  parameter int PROG_CYCLES = spm_pkg::PROG_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_csr_wr,
  input wire logic [7:0] i_csr_wdata,
  output logic [7:0] o_csr_rdata,
  input wire logic i_global_ie,
  input wire logic i_spm,
  input wire logic [15:0] i_z,
  input wire logic [7:0] i_r0,
  input wire logic [7:0] i_r1,
  input wire logic i_lpm,
  input wire logic i_exec_in_boot,
  input wire logic [6:0] i_boot_first_page,
  input wire logic i_enable_fuse_n,
  input wire logic [7:0] i_fuse_low,
  input wire logic [7:0] i_fuse_high,
  input wire logic i_chip_erase,
  output logic o_irq,
  output logic o_stall,
  output logic o_lpm_special,
  output logic [7:0] o_lpm_data,
  output logic o_lpm_blocked,
  output logic o_vec_mask_app,
  output logic o_vec_mask_boot,
  output logic o_ext_prog_lock,
  output logic o_ext_verify_lock,
  output logic o_fuse_lock,
  output logic o_bootlock_lock,
  output logic o_flash_we,
  output logic o_flash_erase,
  output logic [6:0] o_flash_page,
  output logic o_spm_ignored,
  output logic [7:0] o_lock_bit_byte
);
  flash_req_if req();

  logic ie_r;
  logic busy_sec_r;
  logic [4:0] cmd_r;
  logic [2:0] win_r;
  logic [1:0] lpm_win_r;
  logic prog_r;
  logic no_read_while_write_section_r;
  logic [5:0] lock_r;
  logic we_r;
  logic erase_r;
  logic [6:0] page_r;
  logic ign_r;
  logic [7:0] lpm_data_r;
  logic lpm_spec_r;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [4:0] wr_low = i_csr_wdata[4:0];
  wire wr_legal = (wr_low == spm_pkg::CMD_RRE) ||
                  (wr_low == spm_pkg::CMD_LOCK) ||
                  (wr_low == spm_pkg::CMD_PGW) ||
                  (wr_low == spm_pkg::CMD_PGE) ||
                  (wr_low == spm_pkg::CMD_FILL);
  wire arm = i_csr_wr && wr_legal && !prog_r;
  wire win_open = (win_r != 3'h0) && !prog_r;
  wire spm_go = i_spm && win_open && !i_enable_fuse_n;
  wire [6:0] z_page = i_z[spm_pkg::Z_PAGE_HI:spm_pkg::Z_PAGE_LO];
  wire [4:0] z_word = i_z[spm_pkg::Z_WORD_HI:spm_pkg::Z_WORD_LO];
  wire page_no_read_while_write_section = (z_page >= spm_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
  wire page_boot = (z_page >= i_boot_first_page);

  wire [1:0] app_pair = {lock_r[spm_pkg::LB_APP_HI],
                         lock_r[spm_pkg::LB_APP_LO]};
  wire [1:0] boot_pair = {lock_r[spm_pkg::LB_BOOT_HI],
                          lock_r[spm_pkg::LB_BOOT_LO]};
  wire [1:0] mem_pair = {lock_r[spm_pkg::LB_MEM_HI],
                         lock_r[spm_pkg::LB_MEM_LO]};
  wire app_wr_block = !app_pair[0];
  wire app_rd_block = !app_pair[1];
  wire boot_wr_block = !boot_pair[0];
  wire boot_rd_block = !boot_pair[1];
  wire wr_protected = page_boot ? boot_wr_block : app_wr_block;

  wire do_fill = spm_go && cmd_r == spm_pkg::CMD_FILL;
  wire do_rre = spm_go && cmd_r == spm_pkg::CMD_RRE;
  wire do_lock = spm_go && cmd_r == spm_pkg::CMD_LOCK;
  wire do_pg = spm_go && !wr_protected &&
               (cmd_r == spm_pkg::CMD_PGW || cmd_r == spm_pkg::CMD_PGE);
  wire pg_write = cmd_r == spm_pkg::CMD_PGW;
  wire start = do_pg || do_lock;
  wire buf_loading;
  wire [15:0] buf_word0;
  wire buf_abort = (i_csr_wr && i_csr_wdata[spm_pkg::BIT_RRE] &&
                    buf_loading) || (do_pg && pg_write);

  assign req.start = start;
  assign req.op = do_lock ? spm_pkg::OP_LOCK :
                  (pg_write ? spm_pkg::OP_WRITE : spm_pkg::OP_ERASE);
  assign req.page = z_page;
  assign req.lock_data = i_r0[5:0];

  prog_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .req(req)
  );

  page_buffer u_buf (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_wr(do_fill),
    .i_addr(z_word),
    .i_data({i_r1, i_r0}),
    .i_clear(buf_abort),
    .o_loading(buf_loading),
    .o_word0(buf_word0)
  );

  // ---------------------------------------------------------------
  // command window
  // ---------------------------------------------------------------
  // four-cycle window
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_r <= 5'h00;
      win_r <= 3'h0;
    end else if (arm) begin
      cmd_r <= wr_low;
      win_r <= 3'(spm_pkg::WINDOW_CYC);
    end else if (spm_go && start) begin
      win_r <= 3'h0;
    end else if (spm_go || win_r == 3'h1) begin
      cmd_r <= 5'h00;
      win_r <= 3'h0;
    end else if (win_r != 3'h0 && !prog_r) begin
      win_r <= win_r - 3'h1;
    end else if (prog_r && req.done) begin
      cmd_r <= 5'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lpm_win_r <= 2'h0;
    end else if (arm && wr_low == spm_pkg::CMD_LOCK) begin
      lpm_win_r <= 2'(spm_pkg::LPM_WINDOW_CYC);
    end else if (lpm_win_r != 2'h0) begin
      lpm_win_r <= lpm_win_r - 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // programming state
  // ---------------------------------------------------------------
  // enable stays high while busy
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prog_r <= 1'b0;
      no_read_while_write_section_r <= 1'b0;
    end else if (start) begin
      prog_r <= 1'b1;
      no_read_while_write_section_r <= do_pg && page_no_read_while_write_section;
    end else if (req.done) begin
      prog_r <= 1'b0;
      no_read_while_write_section_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_sec_r <= 1'b0;
    end else if (do_pg && !page_no_read_while_write_section) begin
      busy_sec_r <= 1'b1;
    end else if (do_fill || do_rre) begin
      // refused while prog_r, since win_open needs it clear
      busy_sec_r <= 1'b0;
    end
  end

  // lock bits only go to one on chip erase or reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock_r <= spm_pkg::LOCK_ERASED;
    end else if (i_chip_erase) begin
      lock_r <= spm_pkg::LOCK_ERASED;
    end else if (do_lock) begin
      lock_r <= lock_r & i_r0[5:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ie_r <= 1'b0;
    end else if (i_csr_wr) begin
      ie_r <= i_csr_wdata[spm_pkg::BIT_IE];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      we_r <= 1'b0;
      erase_r <= 1'b0;
      page_r <= 7'h00;
      ign_r <= 1'b0;
    end else begin
      we_r <= do_pg && pg_write;
      erase_r <= do_pg && !pg_write;
      ign_r <= i_spm && !spm_go;
      if (do_pg) begin
        page_r <= z_page;
      end
    end
  end

  // ---------------------------------------------------------------
  // load path
  // ---------------------------------------------------------------
  wire lpm_boot_page = page_boot;
  wire lpm_blk = (busy_sec_r && !page_no_read_while_write_section) ||
                 (lpm_boot_page && !i_exec_in_boot && boot_rd_block) ||
                 (!lpm_boot_page && i_exec_in_boot && app_rd_block);
  wire lpm_spec = i_lpm && lpm_win_r != 2'h0;
  wire [7:0] lpm_sel = i_z[0] ? i_fuse_high :
                       (lpm_win_r != 2'h0 ? {2'b11, lock_r} : i_fuse_low);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lpm_data_r <= 8'h00;
      lpm_spec_r <= 1'b0;
    end else begin
      lpm_spec_r <= lpm_spec;
      if (lpm_spec) begin
        lpm_data_r <= lpm_sel;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  wire en_bit = win_open || prog_r;
  assign o_csr_rdata = {ie_r, busy_sec_r, 1'b0,
                        cmd_r[4:1] & {4{en_bit}}, en_bit};
  assign o_irq = ie_r && i_global_ie && !en_bit;
  assign o_stall = no_read_while_write_section_r;
  assign o_lpm_special = lpm_spec_r;
  assign o_lpm_data = lpm_data_r;
  assign o_lpm_blocked = i_lpm && !lpm_spec && lpm_blk;
  assign o_vec_mask_app = app_rd_block && !i_exec_in_boot;
  assign o_vec_mask_boot = boot_rd_block && i_exec_in_boot;
  assign o_ext_prog_lock = mem_pair != 2'b11;
  assign o_fuse_lock = mem_pair != 2'b11;
  assign o_ext_verify_lock = mem_pair == 2'b00;
  assign o_bootlock_lock = mem_pair == 2'b00;
  assign o_flash_we = we_r;
  assign o_flash_erase = erase_r;
  assign o_flash_page = page_r;
  assign o_spm_ignored = ign_r;
  assign o_lock_bit_byte = {2'b11, lock_r};
endmodule

// ===== verification/spm_checker.sv
`timescale 1ns/1ps
module spm_checker #(
  parameter int PROG_CYCLES = spm_pkg::PROG_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_csr_wr,
  input wire logic i_spm,
  input wire logic i_global_ie,
  input wire logic i_enable_fuse_n,
  input wire logic i_chip_erase,
  input wire logic [7:0] o_csr_rdata,
  input wire logic o_irq,
  input wire logic o_stall,
  input wire logic o_ext_prog_lock,
  input wire logic o_ext_verify_lock,
  input wire logic o_fuse_lock,
  input wire logic o_bootlock_lock,
  input wire logic o_flash_we,
  input wire logic o_flash_erase,
  input wire logic [7:0] o_lock_bit_byte
);
  // ----
  // port relations
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  chk_bit5_zero:
  assert property (o_csr_rdata[5] == 1'b0)
    else $error("control bit 5 not zero");
  chk_irq_level:
  assert property (o_irq == (o_csr_rdata[7] && i_global_ie &&
    !o_csr_rdata[0])) else $error("ready interrupt wrong");
  chk_window_close:
  assert property (($rose(o_csr_rdata[0]) && !i_spm && !i_csr_wr) ##1
    (!i_spm && !i_csr_wr)[*3] |=> !o_csr_rdata[0])
    else $error("enable window not closed after four cycles");
  chk_strobe_pulse:
  assert property ((o_flash_we || o_flash_erase) |=>
    !(o_flash_we || o_flash_erase)) else $error("strobe too long");
  chk_fuse_gate:
  assert property ((o_flash_we || o_flash_erase) |-> !i_enable_fuse_n)
    else $error("flash strobe with store disabled");
  chk_lock_only_clear:
  assert property (!$past(i_chip_erase) |->
    (o_lock_bit_byte & ~$past(o_lock_bit_byte)) == 8'h00)
    else $error("lock bit returned to one");
  chk_lock_top_ones:
  assert property (o_lock_bit_byte[7:6] == 2'b11)
    else $error("unused lock bits not one");
  chk_mem_open:
  assert property (o_lock_bit_byte[1:0] == 2'b11 |-> !o_ext_prog_lock &&
    !o_ext_verify_lock && !o_fuse_lock && !o_bootlock_lock)
    else $error("protection active in open mode");
  chk_mem_full:
  assert property (o_lock_bit_byte[1:0] == 2'b00 |-> o_ext_prog_lock &&
    o_ext_verify_lock && o_fuse_lock && o_bootlock_lock)
    else $error("protection missing in full mode");
  chk_stall_in_prog:
  assert property ($rose(o_stall) |-> o_csr_rdata[0])
    else $error("stall without programming");
  chk_busy_in_prog:
  assert property ($rose(o_csr_rdata[6]) |-> o_csr_rdata[0])
    else $error("section busy without programming");
endmodule

bind self_program_control_and_lock spm_checker #(
  .PROG_CYCLES(PROG_CYCLES)
) i_chk (.i_clk, .i_arst_n, .i_csr_wr, .i_spm, .i_global_ie,
  .i_enable_fuse_n, .i_chip_erase, .o_csr_rdata, .o_irq, .o_stall,
  .o_ext_prog_lock, .o_ext_verify_lock, .o_fuse_lock, .o_bootlock_lock,
  .o_flash_we, .o_flash_erase, .o_lock_bit_byte);

// ===== verification/core_model.sv
`timescale 1ns/1ps
module core_model (
  input wire logic i_clk,
  output logic o_csr_wr,
  output logic [7:0] o_wdata,
  output logic o_spm,
  output logic o_lpm,
  output logic [15:0] o_z,
  output logic [15:0] o_rr
);
  // ----
  // core instruction issue
  // ----
  initial begin
    o_csr_wr = 1'b0;
    o_wdata = 8'h00;
    o_spm = 1'b0;
    o_lpm = 1'b0;
    o_z = 16'h0000;
    o_rr = 16'h0000;
  end
  // store one cycle after the write
  // operands flip when idle so stale values never look valid
  task automatic op(input logic [7:0] c, input int k, input logic [15:0] z,
                    input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_csr_wr = 1'b1;
    o_wdata = c;
    @(posedge i_clk);
    #1;
    o_csr_wr = 1'b0;
    o_wdata = ~c;
    o_z = z;
    o_rr = d;
    o_spm = (k == 1);
    o_lpm = (k == 2);
    @(posedge i_clk);
    #1;
    o_spm = 1'b0;
    o_lpm = 1'b0;
    o_z = ~z;
    o_rr = ~d;
  endtask
endmodule

// ===== verification/self_program_control_and_lock_tb_top.sv
`timescale 1ns/1ps
module self_program_control_and_lock_tb_top;
  logic clk, rst_n, gie, fuse_n, ce, csr_wr, spm, lpm;
  logic [7:0] wd, rd, lb, ld, fh, fl, ldat, r0v;
  logic [15:0] z, rr;
  logic [6:0] fpg, pgs, pg;
  logic irq, stl, lsp, epl, evl, fsl, bll, we, er, ign;
  logic eib, vma, vmb, lbk;
  int err_total, compares, seed, n_we, n_er, n_ig, n_ls, lock_m, w;
  int n_bk;
  logic [4:0] cmds [5] = '{spm_pkg::CMD_PGW, spm_pkg::CMD_PGE,
    spm_pkg::CMD_LOCK, spm_pkg::CMD_RRE, spm_pkg::CMD_FILL};
  // ----
  // clock, parts, capture
  // ----
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  core_model i_core (.i_clk(clk), .o_csr_wr(csr_wr), .o_wdata(wd),
    .o_spm(spm), .o_lpm(lpm), .o_z(z), .o_rr(rr));
  self_program_control_and_lock #(.PROG_CYCLES(20)) i_dut (.i_clk(clk),
    .i_arst_n(rst_n), .i_csr_wr(csr_wr), .i_csr_wdata(wd),
    .o_csr_rdata(rd), .i_global_ie(gie), .i_spm(spm), .i_z(z),
    .i_r0(rr[7:0]), .i_r1(rr[15:8]), .i_lpm(lpm), .i_exec_in_boot(eib),
    .i_boot_first_page(7'h70), .i_enable_fuse_n(fuse_n),
    .i_fuse_low(fl), .i_fuse_high(fh), .i_chip_erase(ce), .o_irq(irq),
    .o_stall(stl), .o_lpm_special(lsp), .o_lpm_data(ld),
    .o_lpm_blocked(lbk), .o_vec_mask_app(vma), .o_vec_mask_boot(vmb),
    .o_ext_prog_lock(epl), .o_ext_verify_lock(evl), .o_fuse_lock(fsl),
    .o_bootlock_lock(bll), .o_flash_we(we), .o_flash_erase(er),
    .o_flash_page(fpg), .o_spm_ignored(ign), .o_lock_bit_byte(lb));
  always @(posedge clk) begin
    if (we === 1'b1 || er === 1'b1)
      pgs <= fpg;
    if (we === 1'b1)
      n_we++;
    if (er === 1'b1)
      n_er++;
    if (ign === 1'b1)
      n_ig++;
    if (lbk === 1'b1)
      n_bk++;
    if (lsp === 1'b1)
      ldat <= ld;
    if (lsp === 1'b1)
      n_ls++;
  end
  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic go(input logic [7:0] c, input int k, input logic [15:0] zv,
                    input logic [15:0] d);
    n_we = 0;
    n_er = 0;
    n_ig = 0;
    n_ls = 0;
    n_bk = 0;
    i_core.op(c, k, zv, d);
  endtask
  // a new command only once the window has closed
  task automatic fin;
    w = 0;
    while (rd[0] === 1'b1 && w < 100) begin
      @(posedge clk);
      #1;
      w++;
    end
    chk("enable", rd[0], 0);
    @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done;
  end
  // ----
  // scenarios
  // ----
  initial begin
    seed = 32'h3c629cc3;
    err_total = 0;
    compares = 0;
    lock_m = 255;
    rst_n = 1'b0;
    gie = 1'b1;
    fuse_n = 1'b0;
    ce = 1'b0;
    eib = 1'b0;
    fl = 8'($random(seed));
    fh = 8'($random(seed));
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("csr", rd, spm_pkg::CSR_RESET);
    chk("lockbyte", lb, 8'hff);
    go(8'hff, 0, 0, 0);
    chk("csr", rd, 8'h80);
    chk("irq", irq, 1);
    gie = 1'b0;
    #1;
    chk("irq", irq, 0);
    gie = 1'b1;
    for (int i = 0; i < 5; i++) begin
      go({3'b000, cmds[i]}, 0, 0, 0);
      chk("open", rd, {3'b000, cmds[i]});
      repeat (4) @(posedge clk);
      #1;
      chk("closed", rd, 0);
    end
    for (int i = 0; i < 2; i++) begin
      pg = 7'($unsigned($random(seed)) % 96);
      go(i ? 8'h83 : 8'h85, 1, {3'b000, pg, 6'h00}, 16'($random(seed)));
      repeat (4) @(posedge clk);
      #1;
      chk("strobe", i ? n_er : n_we, 1);
      chk("page", pgs, pg);
      chk("busy", rd[6], 1);
      chk("stall", stl, 0);
      fin;
      chk("irq", irq, 1);
      go(i ? 8'h11 : 8'h01, 1, {10'h0, 5'($random(seed)), 1'b0},
        16'($random(seed)));
      fin;
      chk("busy", rd[6], 0);
    end
    pg = 7'h60 + 7'($unsigned($random(seed)) % 32);
    go(8'h03, 1, {3'b000, pg, 6'h00}, 16'h0);
    repeat (4) @(posedge clk);
    #1;
    chk("stall", stl, 1);
    chk("page", pgs, pg);
    fin;
    // boot and app locks go with the memory locks
    r0v = {2'b11, 2'($random(seed)), 4'b1000};
    lock_m = lock_m & r0v;
    go(8'h09, 1, 16'($random(seed)), {8'($random(seed)), r0v});
    fin;
    chk("lockbyte", lb, {2'b11, lock_m[5:0]});
    chk("memlock", {epl, evl, fsl, bll}, 4'hf);
    chk("vecmask", {vma, vmb}, 2'b00);
    eib = 1'b1;
    #1;
    chk("vecmask", {vma, vmb}, {1'b0, ~lock_m[5]});
    for (int i = 0; i < 2; i++) begin
      go(8'h09, 2, 16'(i), 16'h0);
      fin;
      chk("lpm", n_ls, 1);
      chk("lpmdata", ldat, i ? fh : {2'b11, lock_m[5:0]});
      chk("blocked", n_bk, 0);
    end
    // app pair 10 leaves app reads open from boot code
    go(8'h00, 2, 16'h0040, 16'h0);
    fin;
    chk("blocked", n_bk, 0);
    eib = 1'b0;
    go(8'h00, 2, 16'h1c00, 16'h0);
    fin;
    chk("blocked", n_bk, 16'(~lock_m[5] & 1));
    go(8'h05, 1, 16'h0040, 16'h0);
    fin;
    chk("strobe", n_we, 0);
    fuse_n = 1'b1;
    go(8'h03, 1, 16'h1800, 16'h0);
    fin;
    chk("ignored", n_ig, 1);
    chk("erase", n_er, 0);
    fuse_n = 1'b0;
    ce = 1'b1;
    @(posedge clk);
    #1;
    ce = 1'b0;
    @(posedge clk);
    #1;
    chk("lockbyte", lb, 8'hff);
    test_done;
  end
endmodule
